/* File: src/mat_translate.sv */
`timescale 1ns/1ps
`default_nettype none
module mat_translate #(
  parameter int LINES = 32
) (
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pipeline request
  input wire logic reqValid,
  input wire logic [31:0] reqVaddr,
  input wire logic reqFetch,
  input wire logic reqSuper,
  input wire logic reqStore,
  input wire logic physicalAccessBit,
  input wire logic untranslatedFetchBit,
  input wire logic romFetchEnable,
  input wire logic untranslatedDataBit,
  input wire mat_pkg::mat_inc_t reqFetchInc,
  input wire logic channelIssue,
  // result toward address bus
  output logic respValid,
  output logic [31:0] busAddr,
  output logic busIoSpace,
  output logic busRequest,
  output logic busAccessCancel,
  output logic [1:0] userTagOutputs,
  output logic translated,
  output logic trapValid,
  output logic [3:0] trapVector
);
  import mat_pkg::*;

  // configuration and region mapper registers
  logic [7:0] currentProcessNumber_q;
  logic [1:0] pageSize_q;
  logic [31:0] rmAddr_q [2];
  logic [31:0] rmCtrl_q [2];
  logic [6:0] recommend_q;
  // buffer storage, index {set, line}
  logic [31:0] word0Mem [2*LINES];
  logic [31:0] word1Mem [2*LINES];
  logic [LINES-1:0] usage_q; // set least recently used per line
  // apb answer flops
  logic [31:0] prdata_q;
  logic pslverr_q;

  // true if mode and access kind allow the six protection bits
  function automatic logic protOk(input logic [5:0] prot,
                                  input logic sup,
                                  input logic fetch,
                                  input logic store);
    logic [2:0] grp;
    grp = sup ? prot[5:3] : prot[2:0];
    if (fetch) begin
      return grp[0];
    end
    return store ? grp[1] : grp[2];
  endfunction

  // upper-bit mask of a region of given span code
  function automatic logic [31:0] regionMask(input logic [3:0] span);
    logic [4:0] sh;
    sh = 5'(REGION_BASE_SHIFT) + 5'(span);
    return ~((32'h0000_0001 << sh) - 32'h0000_0001);
  endfunction

  // low-bit mask of the page offset
  function automatic logic [31:0] offsetMask(input logic [1:0] ps);
    logic [4:0] sh;
    sh = 5'(PAGE_BASE_SHIFT) + 5'(ps);
    return (32'h0000_0001 << sh) - 32'h0000_0001;
  endfunction

  // translate decision and process number
  logic doTranslate;
  logic [7:0] procNum;
  always_comb begin
    if (reqFetch) begin
      doTranslate = !untranslatedFetchBit && !romFetchEnable;
    end else if (reqSuper) begin
      doTranslate = !physicalAccessBit && !untranslatedDataBit;
    end else begin
      doTranslate = !untranslatedDataBit;
    end
    procNum = reqSuper ? 8'h00 : currentProcessNumber_q;
  end

  // region mapper matches
  logic [1:0] rmHit;
  logic [31:0] rmPhys [2];
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      logic [31:0] msk;
      logic [31:0] vb;
      logic [31:0] pb;
      msk = regionMask(rmCtrl_q[i][RC_SPAN_LSB +: 4]);
      vb = {rmAddr_q[i][31:16], 16'h0000};
      pb = {rmAddr_q[i][15:0], 16'h0000};
      rmHit[i] = (((reqVaddr ^ vb) & msk) == 32'h0000_0000)
        && (rmCtrl_q[i][RC_OWNER_LSB +: 8] == procNum)
        && rmCtrl_q[i][RC_VALID];
      rmPhys[i] = (pb & msk) | (reqVaddr & ~msk);
    end
  end

  // buffer line select and tag compare
  logic [4:0] lineIdx;
  logic [1:0] setHit;
  logic [31:0] offMask;
  logic [16:0] vaTag;
  always_comb begin
    logic [31:0] sh;
    sh = reqVaddr >> (5'(PAGE_BASE_SHIFT) + 5'(pageSize_q));
    lineIdx = sh[4:0];
    offMask = offsetMask(pageSize_q);
    sh = reqVaddr >> (5'(TAG_BASE_SHIFT) + 5'(pageSize_q));
    vaTag = sh[16:0];
    for (int s = 0; s < 2; s++) begin
      logic [31:0] w0;
      logic [16:0] tg;
      w0 = word0Mem[{s[0], lineIdx}];
      tg = w0[W0_TAG_LSB +: 17] >> pageSize_q;
      setHit[s] = (tg == vaTag)
        && (w0[W0_OWNER_LSB +: 8] == procNum)
        && w0[W0_VALID];
    end
  end

  // buffer physical address with fetch increment
  logic hitSet;
  logic [31:0] tlbW0;
  logic [31:0] tlbW1;
  logic [31:0] tlbPhys;
  always_comb begin
    logic [31:0] off;
    off = reqVaddr; // plain offset unless a fetch asks for more
    hitSet = !setHit[0]; // set 0 wins if software let both qualify
    tlbW0 = word0Mem[{hitSet, lineIdx}];
    tlbW1 = word1Mem[{hitSet, lineIdx}];
    case (reqFetchInc)
      INC_EIGHT: off = reqVaddr + FETCH_INC_8;
      INC_SIXTEEN: off = reqVaddr + FETCH_INC_16;
      default: off = reqVaddr;
    endcase
    if (!reqFetch) begin
      off = reqVaddr;
    end
    tlbPhys = ({tlbW1[W1_FRAME_LSB +: 22], 10'h000} & ~offMask)
      | (off & offMask);
  end

  // pick the first valid translation and check protection
  logic anyHit;
  logic useTlb;
  logic [31:0] selPhys;
  logic selIo;
  logic [1:0] selTag;
  logic [5:0] selProt;
  always_comb begin
    useTlb = 1'b0;
    if (rmHit[0]) begin
      selPhys = rmPhys[0];
      selIo = rmCtrl_q[0][RC_IO];
      selTag = rmCtrl_q[0][RC_TAG_LSB +: 2];
      selProt = rmCtrl_q[0][RC_PROT_LSB +: 6];
    end else if (rmHit[1]) begin
      selPhys = rmPhys[1];
      selIo = rmCtrl_q[1][RC_IO];
      selTag = rmCtrl_q[1][RC_TAG_LSB +: 2];
      selProt = rmCtrl_q[1][RC_PROT_LSB +: 6];
    end else begin // buffer last
      useTlb = 1'b1;
      selPhys = tlbPhys;
      selIo = tlbW1[W1_IO];
      selTag = tlbW1[W1_TAG_LSB +: 2];
      selProt = tlbW0[W0_PROT_LSB +: 6];
    end
    anyHit = (|rmHit) || (|setHit);
  end

  // trap causes of a translating request
  logic protFail;
  logic miss;
  assign protFail = doTranslate && anyHit
    && !protOk(selProt, reqSuper, reqFetch, reqStore);
  assign miss = doTranslate && !anyHit;

  // bus side result, one cycle after the request
  always_ff @(posedge clk) begin
    if (rst) begin
      respValid <= 1'b0;
      busAddr <= RST_ZERO;
      busIoSpace <= 1'b0;
      busRequest <= 1'b0;
      busAccessCancel <= 1'b0;
      userTagOutputs <= 2'h0;
      translated <= 1'b0;
    end else begin
      respValid <= reqValid;
      // untranslated or missed access keeps the virtual address
      busAddr <= doTranslate && anyHit ? selPhys : reqVaddr;
      busIoSpace <= doTranslate && anyHit && selIo;
      if (!reqValid) begin // idle
        busRequest <= 1'b0;
        busAccessCancel <= 1'b0;
      end else if (miss || protFail) begin
        busRequest <= channelIssue;
        busAccessCancel <= channelIssue;
      end else begin
        busRequest <= 1'b1;
        busAccessCancel <= 1'b0;
      end
      // tags only on a permitted translation
      userTagOutputs <= (reqValid && doTranslate && anyHit && !protFail)
        ? selTag : 2'h0;
      translated <= reqValid && doTranslate && anyHit && !protFail;
    end
  end

  // trap raising with its vector
  always_ff @(posedge clk) begin
    if (rst) begin
      trapValid <= 1'b0;
      trapVector <= 4'h0;
    end else begin
      trapValid <= reqValid && (miss || protFail);
      // vector holds until the next trap
      if (reqValid && miss) begin
        trapVector <= VEC_MISS_BASE | {2'b00, reqSuper, !reqFetch};
      end else if (reqValid && protFail) begin
        trapVector <= reqFetch ? VEC_PROT_FETCH : VEC_PROT_DATA;
      end
    end
  end

  // apb decode
  logic apbAccess;
  logic apbWrite;
  logic tlbSel;
  logic [6:0] tlbReg;
  assign apbAccess = psel && penable;
  assign apbWrite = apbAccess && pwrite;
  assign tlbSel = paddr[11:9] == TLB_WIN_SEL;
  assign tlbReg = paddr[8:2];

  // usage bits and recommendation register
  always_ff @(posedge clk) begin
    if (rst) begin
      usage_q <= '0;
      recommend_q <= 7'h00;
    end else if (reqValid && miss) begin
      recommend_q <= {usage_q[lineIdx], lineIdx, 1'b0};
    end else if (reqValid && doTranslate && useTlb && anyHit
                 && !protFail) begin
      // the set that did not hit is now least recently used
      usage_q[lineIdx] <= !hitSet;
    end
  end

  // buffer writes from software
  // memory has no reset: software clears valid bits first
  always_ff @(posedge clk) begin
    if (apbWrite && tlbSel) begin
      if (tlbReg[0]) begin
        word1Mem[{tlbReg[6], tlbReg[5:1]}] <= pwdata;
      end else begin
        word0Mem[{tlbReg[6], tlbReg[5:1]}] <= pwdata;
      end
    end
  end

  // config and region mapper writes
  always_ff @(posedge clk) begin
    if (rst) begin
      currentProcessNumber_q <= 8'h00;
      pageSize_q <= 2'h0;
      rmAddr_q[0] <= RST_ZERO;
      rmAddr_q[1] <= RST_ZERO;
      rmCtrl_q[0] <= RST_ZERO;
      rmCtrl_q[1] <= RST_ZERO;
    end else if (apbWrite) begin
      case (paddr)
        OFS_CFG: begin
          currentProcessNumber_q <= pwdata[CFG_PID_LSB +: 8];
          pageSize_q <= pwdata[CFG_PS_LSB +: 2];
        end
        OFS_RM0_ADDR: rmAddr_q[0] <= pwdata;
        OFS_RM0_CTRL: rmCtrl_q[0] <= pwdata;
        OFS_RM1_ADDR: rmAddr_q[1] <= pwdata;
        OFS_RM1_CTRL: rmCtrl_q[1] <= pwdata;
        // read-only offsets and the window fall through
        default: ;
      endcase
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_q <= RST_ZERO;
      pslverr_q <= 1'b0;
    end else if (psel && !penable) begin
      pslverr_q <= 1'b0;
      prdata_q <= RST_ZERO;
      if (tlbSel) begin
        if (tlbReg[0]) begin
          prdata_q <= {word1Mem[{tlbReg[6], tlbReg[5:1]}][31:1],
                       usage_q[tlbReg[5:1]]};
        end else begin
          prdata_q <= word0Mem[{tlbReg[6], tlbReg[5:1]}];
        end
      end else begin
        case (paddr)
          OFS_CFG: prdata_q <= {22'h0, pageSize_q, currentProcessNumber_q};
          OFS_RM0_ADDR: prdata_q <= rmAddr_q[0];
          OFS_RM0_CTRL: prdata_q <= rmCtrl_q[0];
          OFS_RM1_ADDR: prdata_q <= rmAddr_q[1];
          OFS_RM1_CTRL: prdata_q <= rmCtrl_q[1];
          OFS_RECOMMEND: prdata_q <= {25'h0, recommend_q};
          OFS_STATUS: prdata_q <= {27'h0, trapValid, trapVector};
          default: pslverr_q <= 1'b1; // unmapped
        endcase
      end
    end
  end

  // zero-wait answer in the access cycle
  assign pready = psel && penable;
  assign pslverr = psel && penable && pslverr_q;
  assign prdata = prdata_q;
endmodule
`default_nettype wire

/* File: include/mat_pkg.sv */
package mat_pkg;
  // apb register byte offsets
  localparam logic [11:0] OFS_CFG = 12'h000;
  localparam logic [11:0] OFS_RM0_ADDR = 12'h004;
  localparam logic [11:0] OFS_RM0_CTRL = 12'h008;
  localparam logic [11:0] OFS_RM1_ADDR = 12'h00c;
  localparam logic [11:0] OFS_RM1_CTRL = 12'h010;
  localparam logic [11:0] OFS_RECOMMEND = 12'h014;
  localparam logic [11:0] OFS_STATUS = 12'h018;
  localparam logic [2:0] TLB_WIN_SEL = 3'h1; // paddr[11:9] for buffer
  // config fields
  localparam int CFG_PID_LSB = 0;
  localparam int CFG_PS_LSB = 8;
  // region control fields
  localparam int RC_VALID = 0;
  localparam int RC_IO = 1;
  localparam int RC_TAG_LSB = 2;
  localparam int RC_SPAN_LSB = 4;
  localparam int RC_OWNER_LSB = 8;
  localparam int RC_PROT_LSB = 16;
  // buffer word 0 fields
  localparam int W0_TAG_LSB = 15;
  localparam int W0_VALID = 14;
  localparam int W0_OWNER_LSB = 6;
  localparam int W0_PROT_LSB = 0;
  // buffer word 1 fields
  localparam int W1_FRAME_LSB = 10;
  localparam int W1_TAG_LSB = 8;
  localparam int W1_IO = 7;
  localparam int W1_USAGE = 0;
  // address split constants
  localparam int PAGE_BASE_SHIFT = 10;
  localparam int TAG_BASE_SHIFT = 15;
  localparam int REGION_BASE_SHIFT = 16;
  localparam logic [31:0] FETCH_INC_8 = 32'h0000_0008;
  localparam logic [31:0] FETCH_INC_16 = 32'h0000_0010;
  // reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  // trap vectors
  localparam logic [3:0] VEC_MISS_BASE = 4'h8;
  localparam logic [3:0] VEC_PROT_FETCH = 4'hc;
  localparam logic [3:0] VEC_PROT_DATA = 4'hd;
  // fetch increment codes
  typedef enum logic [1:0] {
    INC_NONE = 2'h0,
    INC_EIGHT = 2'h1,
    INC_SIXTEEN = 2'h2
  } mat_inc_t;
endpackage

/* File: sim/mat_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mat_bus_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic busRequest,
  input wire logic busAccessCancel,
  input wire logic [31:0] busAddr,
  output logic [31:0] lastAddr,
  output logic [7:0] issueCount,
  output logic [7:0] cancelCount
);
  // address bus: latch each placed access, count cancelled ones
  always_ff @(posedge clk) begin
    if (rst) begin
      lastAddr <= 32'h0;
      issueCount <= 8'h0;
      cancelCount <= 8'h0;
    end else if (busRequest) begin
      lastAddr <= busAddr;
      issueCount <= issueCount + 8'h01;
      cancelCount <= cancelCount + {7'h0, busAccessCancel};
    end
  end
endmodule
`default_nettype wire

/* File: sim/mat_translate_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module mat_translate_assertions #(
  parameter int LINES = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reqValid,
  input wire logic [31:0] reqVaddr,
  input wire logic reqFetch,
  input wire logic reqSuper,
  input wire logic physicalAccessBit,
  input wire logic untranslatedFetchBit,
  input wire logic romFetchEnable,
  input wire logic untranslatedDataBit,
  input wire logic channelIssue,
  input wire logic respValid,
  input wire logic [31:0] busAddr,
  input wire logic busRequest,
  input wire logic busAccessCancel,
  input wire logic [1:0] userTagOutputs,
  input wire logic translated,
  input wire logic trapValid,
  input wire logic [3:0] trapVector
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // answer of an untranslated access
  sequence plain_s;
    respValid && !translated && !trapValid && busRequest;
  endsequence
  fetch_bypass_a: assert property (reqValid && reqFetch &&
    (untranslatedFetchBit || romFetchEnable)
    |=> plain_s ##0 busAddr == $past(reqVaddr))
    else $error("fetch not bypassed");
  data_bypass_a: assert property (reqValid && !reqFetch &&
    untranslatedDataBit |=> plain_s ##0 busAddr == $past(reqVaddr))
    else $error("data not bypassed");
  phys_bypass_a: assert property (reqValid && !reqFetch &&
    reqSuper && physicalAccessBit |=> plain_s)
    else $error("physical access translated");
  tag_zero_a: assert property (respValid && !translated
    |-> userTagOutputs == 2'h0) else $error("tags without translation");
  trap_cancel_a: assert property (trapValid |->
    busRequest == $past(channelIssue) && busAccessCancel == busRequest)
    else $error("trap bus issue wrong");
  no_cancel_a: assert property (respValid && !trapValid
    |-> busRequest && !busAccessCancel) else $error("stray cancel");
  miss_vector_a: assert property (trapValid && trapVector < 4'hc
    |-> trapVector == {2'b10, $past(reqSuper), !$past(reqFetch)})
    else $error("miss vector wrong");
  prot_vector_a: assert property (trapValid && trapVector > 4'hb
    |-> trapVector == ($past(reqFetch) ? 4'hc : 4'hd))
    else $error("protection vector wrong");
  resp_latency_a: assert property (reqValid |=> respValid)
    else $error("no answer after one cycle");
endmodule
bind mat_translate mat_translate_assertions #(.LINES(LINES)) chk (.*);
`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checksDone++; if ((g) !== (e)) begin \
  errCount++; $display("FAIL %s exp %h got %h", n, e, g); end end
module tb;
  import mat_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, busAddr, reqVaddr = 32'h0, lastAddr;
  logic pready, pslverr, respValid, busIoSpace, busRequest;
  logic busAccessCancel, translated, trapValid, reqValid = 1'b0;
  logic reqFetch = 1'b0, reqSuper = 1'b0, reqStore = 1'b0;
  logic physicalAccessBit = 1'b0, untranslatedFetchBit = 1'b0;
  logic romFetchEnable = 1'b0, untranslatedDataBit = 1'b0;
  logic channelIssue = 1'b0, rdErr;
  logic [1:0] userTagOutputs;
  logic [3:0] trapVector;
  logic [7:0] issueCount, cancelCount;
  logic [31:0] rdData;
  mat_inc_t reqFetchInc = INC_NONE;
  int errCount = 0, checksDone = 0, cycles = 0;
  mat_translate #(.LINES(32)) DUT (.*);
  mat_bus_model bus (.*);
  // clock, 25 ns
  initial forever #12.5 clk = ~clk;
  task automatic giveVerdict();
    if (errCount == 0 && checksDone > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles > 20000) begin
      errCount++;
      giveVerdict();
    end
  end
  // one apb transfer, setup then access until pready
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // translation request: k = {issue, fetch, super, store, phys}
  task automatic xlat(input logic [31:0] va, input logic [4:0] k,
    input logic [2:0] st, input mat_inc_t inc);
    @(posedge clk);
    reqValid <= 1'b1;
    reqVaddr <= va;
    {channelIssue, reqFetch, reqSuper, reqStore, physicalAccessBit} <= k;
    {untranslatedFetchBit, romFetchEnable, untranslatedDataBit} <= st;
    reqFetchInc <= inc;
    @(posedge clk);
    reqValid <= 1'b0;
    #1;
  endtask
  // compare one answer
  task automatic res(input string n, input logic [31:0] a,
    input logic tr, input logic [3:0] v, input logic [1:0] t);
    `CHK(n, 1'b1, respValid)
    `CHK(n, tr, trapValid)
    if (tr) `CHK(n, v, trapVector) else `CHK(n, a, busAddr)
    `CHK(n, t, userTagOutputs)
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, OFS_CFG, 32'h0);
    `CHK("cfg", 32'h0, rdData)
    apb(1'b0, 12'h0fc, 32'h0);
    `CHK("unmapped", 1'b1, rdErr)
    // clear all buffer entries
    for (int i = 0; i < 64; i++) apb(1'b1, 12'h200 + 12'(i * 8), 32'h0);
    // every miss vector, data misses with a cancelled bus issue, fetch misses without
    for (int j = 0; j < 4; j++) begin
      xlat(32'h0040_0000, {j[0], ~j[0], j[1], 2'b00}, 3'h0, INC_NONE);
      res("miss", 32'h0, 1'b1, 4'h8 + 4'(j), 2'h0);
      `CHK("cancel", j[0], busAccessCancel)
    end
    // bus model counted the two issued, cancelled misses
    @(posedge clk);
    #1 `CHK("issued", 8'h02, issueCount)
    `CHK("cancels", 8'h02, cancelCount)
    // region mappers, process 5
    apb(1'b1, OFS_CFG, 32'h0000_0005);
    apb(1'b1, OFS_RM0_ADDR, 32'h1234_abcc);
    apb(1'b1, OFS_RM0_CTRL, 32'h003f_050f);
    apb(1'b1, OFS_RM1_ADDR, 32'h1234_5555);
    apb(1'b1, OFS_RM1_CTRL, 32'h003f_0501);
    xlat(32'h1234_5678, 5'h0, 3'h0, INC_NONE);
    res("rm0", 32'habcc_5678, 1'b0, 4'h0, 2'h3);
    `CHK("io", 1'b1, busIoSpace)
    xlat(32'h1234_5678, 5'h04, 3'h0, INC_NONE);
    res("sup", 32'h0, 1'b1, 4'hb, 2'h0);
    apb(1'b1, OFS_RM0_CTRL, 32'h003f_051f);
    xlat(32'h1235_5678, 5'h0, 3'h0, INC_NONE);
    res("span1", 32'habcd_5678, 1'b0, 4'h0, 2'h3);
    apb(1'b1, OFS_RM0_CTRL, 32'h003f_05ff);
    xlat(32'h1fff_0000, 5'h0, 3'h0, INC_NONE);
    res("span15", 32'h9fff_0000, 1'b0, 4'h0, 2'h3);
    apb(1'b1, OFS_RM0_CTRL, 32'h003f_050e);
    xlat(32'h1234_5678, 5'h0, 3'h0, INC_NONE);
    res("rm1", 32'h5555_5678, 1'b0, 4'h0, 2'h0);
    `CHK("mem", 1'b0, busIoSpace)
    apb(1'b1, OFS_RM0_CTRL, 32'h0000_050f);
    xlat(32'h1234_5678, 5'h0, 3'h0, INC_NONE);
    res("protd", 32'h0, 1'b1, 4'hd, 2'h0);
    xlat(32'h1234_5678, 5'h08, 3'h0, INC_NONE);
    res("protf", 32'h0, 1'b1, 4'hc, 2'h0);
    apb(1'b1, OFS_RM0_CTRL, 32'h0);
    apb(1'b1, OFS_RM1_CTRL, 32'h0);
    // untranslated accesses
    xlat(32'h1234_5678, 5'h05, 3'h0, INC_NONE);
    res("pa", 32'h1234_5678, 1'b0, 4'h0, 2'h0);
    `CHK("noxl", 1'b0, translated)
    @(posedge clk);
    #1 `CHK("bus", 32'h1234_5678, lastAddr)
    xlat(32'h2000_0010, 5'h0, 3'h1, INC_NONE);
    res("pd", 32'h2000_0010, 1'b0, 4'h0, 2'h0);
    xlat(32'h3000_0020, 5'h08, 3'h2, INC_NONE);
    res("re", 32'h3000_0020, 1'b0, 4'h0, 2'h0);
    xlat(32'h3000_0040, 5'h08, 3'h4, INC_NONE);
    res("pi", 32'h3000_0040, 1'b0, 4'h0, 2'h0);
    // buffer, 8 kb pages, set 1 line 3, unused bits zero
    apb(1'b1, OFS_CFG, 32'h0000_0305);
    apb(1'b1, 12'h318, 32'h0004_417f);
    apb(1'b1, 12'h31c, 32'h2468_a100);
    xlat(32'h0004_6abc, 5'h0, 3'h0, INC_NONE);
    res("hit", 32'h2468_aabc, 1'b0, 4'h0, 2'h1);
    `CHK("xl", 1'b1, translated)
    `CHK("tlbmem", 1'b0, busIoSpace)
    xlat(32'h0004_6abc, 5'h08, 3'h0, INC_SIXTEEN);
    res("inc", 32'h2468_aacc, 1'b0, 4'h0, 2'h1);
    xlat(32'h0004_7ffc, 5'h08, 3'h0, INC_EIGHT);
    res("wrap", 32'h2468_a004, 1'b0, 4'h0, 2'h1);
    xlat(32'h0004_4abc, 5'h0, 3'h0, INC_NONE);
    res("line", 32'h0, 1'b1, 4'h9, 2'h0);
    xlat(32'h0004_6abc, 5'h04, 3'h0, INC_NONE);
    res("owner", 32'h0, 1'b1, 4'hb, 2'h0);
    apb(1'b0, OFS_RECOMMEND, 32'h0);
    `CHK("lru", 32'h0000_0006, rdData)
    // set 0 entry owned by supervisor only, so one set qualifies
    apb(1'b1, 12'h218, 32'h0004_403f);
    apb(1'b1, 12'h21c, 32'h1357_8280);
    xlat(32'h0004_6abc, 5'h04, 3'h0, INC_NONE);
    res("set0", 32'h1357_8abc, 1'b0, 4'h0, 2'h2);
    `CHK("tlbio", 1'b1, busIoSpace)
    xlat(32'h0008_6abc, 5'h0, 3'h0, INC_NONE);
    res("miss3", 32'h0, 1'b1, 4'h9, 2'h0);
    apb(1'b0, OFS_RECOMMEND, 32'h0);
    `CHK("lru1", 32'h0000_0046, rdData)
    // second reset in mid-run clears config and recommendation
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, OFS_CFG, 32'h0);
    `CHK("rstcfg", 32'h0, rdData)
    apb(1'b0, OFS_RECOMMEND, 32'h0);
    `CHK("rstrec", 32'h0, rdData)
    giveVerdict();
  end
endmodule
`default_nettype wire
